// File: verilog/ueffc_top.sv
/*
 * ueffc_top: frame fifo controller. Builds the receive status word,
 * runs the receive flush and stop handshake, buffers bulk-out packets
 * in the transmit fifo and splits them into frames for the mac.
 * Assumes mac and usb sides are logic on clk; registers on a plain port.
 */
// Functional notes
// - length field mismatch sets bit 12
// - runt sets bit 11, dropped unless pass-bad
// - multicast destination sets bit 10
// - over 1518 bytes sets bit 7, no truncation
// - late collision sets bit 6
// - bit 5 when type over 1500, not below 14 bytes
// - watchdog beyond 2048 bytes sets bit 4
// - rx error during frame sets bit 3
// - dribble bits set bit 2, not with 6
// - crc error or rx error sets bit 1
// - dribble without crc error is valid
// - flush resets receive fifo pointers
// - flush bit clears itself when done
// - disable receiver, pulse when halted
// - 8 KB tx fifo with rewindable head
// - store raw, extract frames on read
// - two command words start every buffer
// - command b mismatch raises tx error
// - data count versus frame length checked
// - bit 15 ors bits 11,7,6,1; code takes latched late only, not rx_collision at rx_end
// - first and last segment bits delimit
// - skip start offset bytes
`timescale 1ns/1ps
`default_nettype none
module ueffc_top
	import ueffc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic rx_start,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_er,
	input wire logic rx_collision,
	input wire logic rx_crc_bad,
	input wire logic [2:0] rx_dribble,
	input wire logic speed_10m,
	input wire logic rx_end,
	output logic [31:0] rx_status_word,
	output logic rx_status_valid,
	output logic rx_frame_drop,
	output logic rx_enable,
	output logic rx_fifo_flush,
	output logic receiver_stopped_pulse,
	input wire logic usb_wr_valid,
	input wire logic [31:0] usb_wr_data,
	input wire logic usb_pkt_end,
	input wire logic usb_pkt_err,
	output logic usb_wr_ready,
	output logic tx_valid,
	output logic [31:0] tx_data,
	output logic [3:0] tx_be,
	output logic tx_first,
	output logic tx_last,
	input wire logic tx_ready,
	output logic transmitter_error_flag
);
	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	logic [2:0] ctrl;
	logic halted;
	logic [TXF_AW-1:0] wr_ptr;
	logic [TXF_AW-1:0] head_ptr;
	logic [TXF_AW-1:0] rd_ptr;
	logic tx_err_set;
	logic [TXF_AW-1:0] level;
	assign level = wr_ptr - rd_ptr;

	// control bits; flush self-clears
	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl <= CTRL_RESET;
		else if (reg_wr && reg_addr == REG_CTRL)
			ctrl <= reg_wdata[2:0];
		else if (rx_fifo_flush)
			ctrl[CTRL_FLUSH] <= 1'b0;
	end

	// transmitter error: write one clears, a new error wins
	always_ff @(posedge clk)
	begin
		if (rst)
			transmitter_error_flag <= 1'b0;
		else if (tx_err_set)
			transmitter_error_flag <= 1'b1;
		else if (reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_TXERR])
			transmitter_error_flag <= 1'b0;
	end

	// read data one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (rst)
			reg_rdata <= 32'h0;
		else if (!reg_rd)
			reg_rdata <= 32'h0;
		else
			case (reg_addr)
				REG_CTRL: reg_rdata <= {29'h0, ctrl};
				REG_STAT: reg_rdata <= {30'h0, transmitter_error_flag, halted};
				REG_RXSW: reg_rdata <= rx_status_word;
				REG_TXLV: reg_rdata <= {21'h0, level};
				default: reg_rdata <= 32'h0;
			endcase
	end

	// ----------------------------------------------------------------
	// receiver stop and flush
	// ----------------------------------------------------------------
	logic rx_active;

	// frame in progress
	always_ff @(posedge clk)
	begin
		if (rst)
			rx_active <= 1'b0;
		else if (rx_start)
			rx_active <= 1'b1;
		else if (rx_end)
			rx_active <= 1'b0;
	end

	// receiver halts only at a frame boundary
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_enable <= 1'b0;
			halted <= 1'b1;
			receiver_stopped_pulse <= 1'b0;
		end
		else
		begin
			rx_enable <= ctrl[CTRL_RECEIVER_ENABLE_BIT];
			halted <= !ctrl[CTRL_RECEIVER_ENABLE_BIT] && !rx_active;
			receiver_stopped_pulse <= !halted && !ctrl[CTRL_RECEIVER_ENABLE_BIT] && !rx_active;
		end
	end

	// one-cycle pointer reset pulse to the rx fifo
	always_ff @(posedge clk)
	begin
		if (rst)
			rx_fifo_flush <= 1'b0;
		else
			rx_fifo_flush <= ctrl[CTRL_FLUSH] && !rx_fifo_flush;
	end

	// ----------------------------------------------------------------
	// receive status word
	// ----------------------------------------------------------------
	logic [13:0] cnt;
	logic [15:0] lentype;
	logic mcast;
	logic bcast;
	logic late;
	logic er_seen;
	logic [13:0] payload;
	logic runt;
	logic le;
	logic long_f;
	logic crc_f;
	logic drib;
	assign payload = cnt - HDR_CRC_LEN;
	assign runt = cnt < COLL_WINDOW;
	assign long_f = cnt > MAX_FRAME;
	assign crc_f = rx_crc_bad || er_seen || rx_er;

	// per-frame capture of count and header fields
	always_ff @(posedge clk)
	begin
		if (rst || rx_start)
		begin
			cnt <= 14'h0;
			lentype <= 16'h0;
			mcast <= 1'b0;
			bcast <= 1'b1;
			late <= 1'b0;
			er_seen <= 1'b0;
		end
		else
		begin
			if (rx_byte_valid && cnt != 14'h3FFF)
				cnt <= cnt + 14'h1;
			// group bit of first address byte
			if (rx_byte_valid && cnt == 14'h0)
				mcast <= rx_byte[0];
			if (rx_byte_valid && cnt < 14'h6 && rx_byte != 8'hFF)
				bcast <= 1'b0;
			if (rx_byte_valid && cnt == 14'hC)
				lentype[15:8] <= rx_byte;
			if (rx_byte_valid && cnt == 14'hD)
				lentype[7:0] <= rx_byte;
			if (rx_collision && cnt >= COLL_WINDOW)
				late <= 1'b1;
			// any rx error in the frame
			if (rx_er)
				er_seen <= 1'b1;
		end
	end

	// length check and dribble qualification
	always_comb
	begin
		le = 1'b0;
		if (cnt >= MIN_TYPE_LEN && lentype <= MAX_LENTYPE)
			le = (payload >= MIN_PAYLOAD) ? (lentype != {2'h0, payload})
				: (lentype > {2'h0, payload});
		// dribble bits only by mode, never with late collision
		drib = !(late || rx_collision) &&
			(speed_10m ? (rx_dribble >= DRIB_10M) : (rx_dribble == DRIB_MII));
	end

	// status word and drop decision at frame end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_status_word <= 32'h0;
			rx_status_valid <= 1'b0;
			rx_frame_drop <= 1'b0;
		end
		else
		begin
			rx_status_valid <= rx_end;
			// runts pass only with pass-bad set
			rx_frame_drop <= rx_end && runt && !ctrl[CTRL_PASSBAD];
			if (rx_end)
			begin
				rx_status_word <= 32'h0;
				rx_status_word[29:RS_LEN_LO] <= cnt;
				rx_status_word[RS_BCAST] <= bcast && cnt >= 14'h6;
				rx_status_word[RS_LE] <= le;
				rx_status_word[RS_RUNT] <= runt;
				rx_status_word[RS_MCAST] <= mcast;
				rx_status_word[RS_LONG] <= long_f;
				rx_status_word[RS_LATE] <= late || (rx_collision && !runt);
				// type frame, never below 14 bytes
				rx_status_word[RS_TYPE] <= cnt >= MIN_TYPE_LEN && lentype > MAX_LENTYPE;
				rx_status_word[RS_WDOG] <= cnt > WDOG_LEN;
				rx_status_word[RS_MIIER] <= er_seen || rx_er;
				// dribble alone leaves the frame valid
				rx_status_word[RS_DRIB] <= drib;
				rx_status_word[RS_CRC] <= crc_f;
				rx_status_word[RS_ES] <= runt || long_f || late || crc_f;
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit fifo write side
	// ----------------------------------------------------------------
	logic [31:0] txmem [0:(1<<TXF_AW)-1];
	logic pop;

	// write pointer, head commit and rewind
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			head_ptr <= '0;
		end
		else if (usb_pkt_err)
			wr_ptr <= head_ptr;
		else if (usb_pkt_end)
			head_ptr <= wr_ptr;
		else if (usb_wr_valid && usb_wr_ready)
			wr_ptr <= wr_ptr + 11'h1;
	end

	always_ff @(posedge clk)
	begin
		if (usb_wr_valid && usb_wr_ready && !usb_pkt_err && !usb_pkt_end)
			txmem[wr_ptr] <= usb_wr_data;
	end

	// space flag, kept a few words short of full
	always_ff @(posedge clk)
	begin
		if (rst)
			usb_wr_ready <= 1'b0;
		else
			usb_wr_ready <= level < TXF_SLACK;
	end

	// ----------------------------------------------------------------
	// transmit fifo read side: frame extraction
	// ----------------------------------------------------------------
	ueffc_tp_t tp;
	logic [31:0] cmdb;
	logic [31:0] word;
	logic [1:0] off;
	logic [10:0] size;
	logic seg_first;
	logic seg_last;
	logic [11:0] words_left;
	logic [12:0] byte_pos;
	logic [12:0] sum;
	logic [12:0] next_sum;
	logic [3:0] next_be;
	assign word = txmem[rd_ptr];
	assign pop = (rd_ptr != head_ptr) && (tp != TP_DATA || !tx_valid || tx_ready);
	assign next_sum = (seg_first ? 13'h0 : sum) + {2'h0, size};

	// byte lanes inside offset and buffer size
	always_comb
	begin
		for (int l = 0; l < 4; l++)
			next_be[l] = (byte_pos + 13'(l) >= {11'h0, off}) &&
				(byte_pos + 13'(l) < {11'h0, off} + {2'h0, size});
	end

	// command parse and data walk
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tp <= TP_CMDA;
			rd_ptr <= '0;
			cmdb <= 32'h0;
			off <= 2'h0;
			size <= 11'h0;
			seg_first <= 1'b0;
			seg_last <= 1'b0;
			words_left <= 12'h0;
			byte_pos <= 13'h0;
			sum <= 13'h0;
			tx_err_set <= 1'b0;
		end
		else
		begin
			tx_err_set <= 1'b0;
			if (pop)
			begin
				rd_ptr <= rd_ptr + 11'h1;
				case (tp)
					TP_CMDA:
					begin
						off <= word[CA_OFF_LO+1:CA_OFF_LO];
						size <= word[CA_SIZE_HI:0];
						seg_first <= word[CA_FIRST];
						seg_last <= word[CA_LAST];
						words_left <= 12'((13'(word[CA_SIZE_HI:0])
							+ 13'(word[CA_OFF_LO+1:CA_OFF_LO]) + 13'h3) >> 2);
						byte_pos <= 13'h0;
						tp <= TP_CMDB;
					end
					TP_CMDB:
					begin
						cmdb <= word;
						sum <= next_sum;
						// command b equal apart from checksum bit
						if (!seg_first && ((word ^ cmdb) & CB_CMP_MASK) != 32'h0)
							tx_err_set <= 1'b1;
						if (seg_last && next_sum != {2'h0, word[CB_LEN_HI:0]})
							tx_err_set <= 1'b1;
						tp <= (words_left == 12'h0) ? TP_CMDA : TP_DATA;
					end
					TP_DATA:
					begin
						words_left <= words_left - 12'h1;
						byte_pos <= byte_pos + 13'h4;
						if (words_left == 12'h1)
							tp <= TP_CMDA;
					end
					default: tp <= TP_CMDA;
				endcase
			end
		end
	end

	// mac word register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tx_valid <= 1'b0;
			tx_data <= 32'h0;
			tx_be <= 4'h0;
			tx_first <= 1'b0;
			tx_last <= 1'b0;
		end
		else if (pop && tp == TP_DATA)
		begin
			tx_valid <= 1'b1;
			tx_data <= word;
			tx_be <= next_be;
			tx_first <= seg_first && byte_pos == 13'h0;
			tx_last <= seg_last && words_left == 12'h1;
		end
		else if (tx_ready)
			tx_valid <= 1'b0;
	end
endmodule : ueffc_top
`default_nettype wire

// File: verilog/ueffc_pkg.sv
/*
 * ueffc_pkg: constants of the usb / ethernet frame fifo controller.
 * Assumes one device clock; offsets are byte addresses on the register port.
 */
`default_nettype none
package ueffc_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_RXSW = 8'h08;
	localparam logic [7:0] REG_TXLV = 8'h0C;
	localparam int CTRL_RECEIVER_ENABLE_BIT = 0;
	localparam int CTRL_FLUSH = 1;
	localparam int CTRL_PASSBAD = 2;
	localparam int STAT_HALTED = 0;
	localparam int STAT_TXERR = 1;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// ----------------------------------------------------------------
	// receive status word fields
	// ----------------------------------------------------------------
	localparam int RS_ES = 15;
	localparam int RS_BCAST = 13;
	localparam int RS_LE = 12;
	localparam int RS_RUNT = 11;
	localparam int RS_MCAST = 10;
	localparam int RS_LONG = 7;
	localparam int RS_LATE = 6;
	localparam int RS_TYPE = 5;
	localparam int RS_WDOG = 4;
	localparam int RS_MIIER = 3;
	localparam int RS_DRIB = 2;
	localparam int RS_CRC = 1;
	localparam int RS_LEN_LO = 16;
	localparam logic [13:0] COLL_WINDOW = 14'h0040;
	localparam logic [13:0] MAX_FRAME = 14'h05EE;
	localparam logic [15:0] MAX_LENTYPE = 16'h05DC;
	localparam logic [13:0] MIN_TYPE_LEN = 14'h000E;
	localparam logic [13:0] WDOG_LEN = 14'h0800;
	localparam logic [13:0] HDR_CRC_LEN = 14'h0012;
	localparam logic [13:0] MIN_PAYLOAD = 14'h002E;
	localparam logic [2:0] DRIB_MII = 3'h4;
	localparam logic [2:0] DRIB_10M = 3'h3;
	// ----------------------------------------------------------------
	// transmit fifo and command words
	// ----------------------------------------------------------------
	localparam int TXF_AW = 11;
	localparam logic [10:0] TXF_SLACK = 11'h7FC;
	localparam int CA_SIZE_HI = 10;
	localparam int CA_LAST = 12;
	localparam int CA_FIRST = 13;
	localparam int CA_OFF_LO = 16;
	localparam int CB_LEN_HI = 10;
	localparam int CB_CKSUM = 14;
	localparam logic [31:0] CB_CMP_MASK = 32'hFFFFBFFF;
	typedef enum logic [2:0] {
		TP_CMDA = 3'b001,
		TP_CMDB = 3'b010,
		TP_DATA = 3'b100
	} ueffc_tp_t;
endpackage : ueffc_pkg
`default_nettype wire

// File: tb/ueffc_properties.sv
/*
 * ueffc_props: concurrent checks on the ports of ueffc_top, bound below.
 * Assumes the single clk domain and the synchronous active-high rst.
 */
`timescale 1ns/1ps
`default_nettype none
module ueffc_props
	import ueffc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [31:0] rx_status_word,
	input wire logic rx_status_valid,
	input wire logic rx_frame_drop,
	input wire logic rx_fifo_flush,
	input wire logic receiver_stopped_pulse,
	input wire logic tx_valid,
	input wire logic [31:0] tx_data,
	input wire logic [3:0] tx_be,
	input wire logic tx_ready
);
	// ------------------------------------------------------------
	// receive status, control and transmit hold checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	logic [13:0] len;
	logic [31:0] w;
	// byte count field of the status word
	assign w = rx_status_word;
	assign len = w[29:16];
	sequence s_flush_wr;
		reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_FLUSH];
	endsequence
	sequence s_flush_pulse;
		rx_fifo_flush ##1 !rx_fifo_flush;
	endsequence
	a_es_summary: assert property (rx_status_valid |->
		w[RS_ES] == (w[RS_RUNT] | w[RS_LONG] | w[RS_LATE] | w[RS_CRC]))
		else $error("error summary wrong");
	a_runt_flag: assert property (rx_status_valid |-> w[RS_RUNT] == (len < 14'h0040))
		else $error("runt flag wrong");
	a_runt_drop: assert property (rx_frame_drop |-> rx_status_valid && w[RS_RUNT])
		else $error("drop without runt");
	a_long_flag: assert property (rx_status_valid |-> w[RS_LONG] == (len > 14'h05EE))
		else $error("long flag wrong");
	a_wdog_flag: assert property (rx_status_valid |-> w[RS_WDOG] == (len > 14'h0800))
		else $error("watchdog flag wrong");
	a_type_short: assert property (rx_status_valid && len < 14'h000E |-> !w[RS_TYPE])
		else $error("type flag on short frame");
	a_le_short: assert property (rx_status_valid && len < 14'h000E |-> !w[RS_LE])
		else $error("length flag on short frame");
	a_drib_late: assert property (rx_status_valid && w[RS_LATE] |-> !w[RS_DRIB])
		else $error("dribble with late collision");
	a_mii_crc: assert property (rx_status_valid && w[RS_MIIER] |-> w[RS_CRC])
		else $error("rx error without crc flag");
	a_flush_pulse: assert property (s_flush_wr |-> ##[1:3] s_flush_pulse)
		else $error("flush pulse missing");
	a_stop_single: assert property (receiver_stopped_pulse |=> !receiver_stopped_pulse[*2])
		else $error("stopped pulse too long");
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_be))
		else $error("tx word not held");
endmodule : ueffc_props
bind ueffc_top ueffc_props props_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
	.rx_status_word, .rx_status_valid, .rx_frame_drop, .rx_fifo_flush,
	.receiver_stopped_pulse, .tx_valid, .tx_data, .tx_be, .tx_ready);
`default_nettype wire

// File: tb/ueffc_mac_sink.sv
/*
 * ueffc_mac_sink: mac side model taking frame words from ueffc_top.
 * Assumes the bench clock and reset; slow makes it stall three in four.
 */
`timescale 1ns/1ps
`default_nettype none
module ueffc_mac_sink
(
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	output logic tx_ready
);
	logic [1:0] cnt;
	// free running stall pattern
	always_ff @(posedge clk)
	begin
		if (rst)
			cnt <= 2'h0;
		else
			cnt <= cnt + 2'h1;
	end
	assign tx_ready = !rst && (!slow || cnt == 2'h3);
endmodule : ueffc_mac_sink
`default_nettype wire

// File: tb/test_usb_ethernet_frame_fifo_ctrl.sv
/*
 * test_usb_ethernet_frame_fifo_ctrl: self-checking bench for ueffc_top.
 * Assumes ueffc_mac_sink and the bound property checker are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module test_usb_ethernet_frame_fifo_ctrl
	import ueffc_pkg::*;
;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_start = 0, rx_byte_valid = 0;
	logic rx_er = 0, rx_collision = 0, rx_crc_bad = 0, speed_10m = 0, rx_end = 0;
	logic usb_wr_valid = 0, usb_pkt_end = 0, usb_pkt_err = 0, slow = 0, ign = 0;
	logic [7:0] reg_addr = 8'h00, rx_byte = 8'h00;
	logic [2:0] rx_dribble = 3'h0;
	logic [31:0] reg_wdata = 32'h0, usb_wr_data = 32'h0, seed = 32'h0000433D;
	logic [31:0] reg_rdata, rx_status_word, tx_data, last_sw, pb, r;
	logic rx_status_valid, rx_frame_drop, rx_enable, rx_fifo_flush, receiver_stopped_pulse;
	logic usb_wr_ready, tx_valid, tx_first, tx_last, tx_ready, transmitter_error_flag;
	logic [3:0] tx_be;
	logic [39:0] rxq[$], txq[$];
	int miscompares = 0, num_checks = 0;
	ueffc_top uut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_start, .rx_byte_valid, .rx_byte, .rx_er, .rx_collision, .rx_crc_bad,
		.rx_dribble, .speed_10m, .rx_end, .rx_status_word, .rx_status_valid,
		.rx_frame_drop, .rx_enable, .rx_fifo_flush, .receiver_stopped_pulse,
		.usb_wr_valid, .usb_wr_data, .usb_pkt_end, .usb_pkt_err, .usb_wr_ready,
		.tx_valid, .tx_data, .tx_be, .tx_first, .tx_last, .tx_ready,
		.transmitter_error_flag);
	ueffc_mac_sink sink (.clk, .rst, .slow, .tx_ready);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// 100 ns clock
	always #50 clk = ~clk;
	task chk(input logic [39:0] s, input logic [39:0] e);
		num_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function logic [31:0] m(input logic [3:0] b);
		return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	endfunction : m
	task close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, e});
	endtask : rd
	// counts one control pulse after a write
	task cnt(input logic sel);
		logic [39:0] n;
		n = 40'h0;
		repeat (20)
		begin
			@(posedge clk);
			n = n + (sel ? rx_fifo_flush : receiver_stopped_pulse);
		end
		chk(n, 40'h1);
	endtask : cnt
	task frame(input int n, input logic [15:0] lt, input logic mc, input int er, col,
		input logic crc, input logic [2:0] dr, input logic spd);
		logic [31:0] w;
		int l;
		l = lt;
		w = {2'h0, n[13:0], 16'h0000};
		w[12] = l <= 1500 && n >= 14 && (n - 18 >= 46 ? l != n - 18 : l > n - 18);
		w[11] = n < 64;
		w[10] = mc;
		w[7] = n > 1518;
		w[6] = col >= 64;
		w[5] = n >= 14 && l > 1500;
		w[4] = n > 2048;
		w[3] = er >= 0;
		w[2] = !w[6] && (spd ? dr >= 3'h3 : dr == 3'h4);
		w[1] = crc || er >= 0;
		w[15] = w[11] | w[7] | w[6] | w[1];
		@(posedge clk);
		rx_start <= 1'b1;
		speed_10m <= spd;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			r = rnd();
			r[0] = i == 0 ? mc : r[0];
			rx_start <= 1'b0;
			rx_byte_valid <= 1'b1;
			rx_byte <= i == 1 ? 8'h00 : i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : r[7:0];
			rx_er <= i == er;
			rx_collision <= i == col;
		end
		@(posedge clk);
		rx_byte_valid <= 1'b0;
		rx_er <= 1'b0;
		rx_collision <= 1'b0;
		rx_end <= 1'b1;
		rx_crc_bad <= crc;
		rx_dribble <= dr;
		rxq.push_back({7'h00, w[11] && !pb[2], w});
		@(posedge clk);
		rx_end <= 1'b0;
		last_sw = w;
	endtask : frame
	task usbw(input logic [31:0] d);
		@(posedge clk);
		usb_wr_valid <= 1'b1;
		usb_wr_data <= d;
		@(posedge clk);
		while (usb_wr_ready !== 1'b1)
			@(posedge clk);
		usb_wr_valid <= 1'b0;
	endtask : usbw
	// one buffer: command a, command b, data; p notes the expected words
	task txbuf(input int off, sz, input logic f, l, input int len, input logic ck, p);
		logic [3:0] be;
		int nw;
		nw = (off + sz + 3) / 4;
		usbw({14'h0000, off[1:0], 2'h0, f, l, 1'b0, sz[10:0]});
		usbw({17'h00000, ck, 3'h0, len[10:0]});
		for (int k = 0; k < nw; k++)
		begin
			r = rnd();
			for (int j = 0; j < 4; j++)
				be[j] = 4 * k + j >= off && 4 * k + j < off + sz;
			if (p)
				txq.push_back({2'h0, f && k == 0, l && k == nw - 1, be, r & m(be)});
			usbw(r);
		end
	endtask : txbuf
	task pend(input logic err);
		@(posedge clk);
		usb_pkt_end <= !err;
		usb_pkt_err <= err;
		@(posedge clk);
		usb_pkt_end <= 1'b0;
		usb_pkt_err <= 1'b0;
	endtask : pend
	// ------------------------------------------------------------
	// scoreboards, watchdog, stimulus
	// ------------------------------------------------------------
	// status word and drop flag against the oldest note
	always @(posedge clk)
		if (!rst && rx_status_valid === 1'b1)
			chk({7'h00, rx_frame_drop, rx_status_word},
				rxq.size() ? rxq.pop_front() : 40'h0);
	// mac words against the oldest note
	always @(posedge clk)
		if (!rst && !ign && tx_valid === 1'b1 && tx_ready === 1'b1)
			chk({2'h0, tx_first, tx_last, tx_be, tx_data & m(tx_be)},
				txq.size() ? txq.pop_front() : 40'h0);
	// run needs about 7k to 10k cycles; cut at 30k
	initial
	begin
		#3000000;
		miscompares++;
		close_out();
	end
	initial
	begin
		pb = 32'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wr(8'h10, 32'hFFFFFFFF);
		rd(REG_CTRL, 32'h0);
		rd(REG_STAT, 32'h1);
		rd(REG_TXLV, 32'h0);
		rd(8'h10, 32'h0);
		wr(REG_CTRL, 32'h1);
		frame(64, 16'h002E, 1, -1, -1, 0, 3'h0, 0);
		frame(63, 16'h0800, 0, -1, -1, 0, 3'h0, 0);
		frame(13, 16'h0800, 0, -1, -1, 0, 3'h0, 0);
		frame(60, 16'h002B, 0, -1, -1, 0, 3'h0, 0);
		frame(1518, 16'h0800, 0, -1, -1, 0, 3'h0, 0);
		frame(1519, 16'h05DC, 0, -1, -1, 0, 3'h0, 0);
		frame(2049, 16'h0800, 0, -1, -1, 0, 3'h0, 0);
		frame(100, 16'h0032, 0, 20, -1, 0, 3'h0, 0);
		frame(80, 16'h0800, 0, -1, -1, 1, 3'h0, 0);
		frame(200, 16'h0800, 0, -1, 100, 0, 3'h4, 0);
		frame(200, 16'h0800, 0, -1, 10, 0, 3'h4, 0);
		frame(200, 16'h0800, 0, -1, -1, 0, 3'h3, 1);
		frame(200, 16'h0800, 0, -1, -1, 0, 3'h3, 0);
		repeat (12)
		begin
			r = rnd();
			frame(18 + r[7:0], {5'h00, r[18:8]}, r[19], r[25] ? 5 : -1, r[26] ? 5 : -1,
				r[20], r[23:21], r[24]);
		end
		rd(REG_RXSW, last_sw);
		pb = 32'h4;
		wr(REG_CTRL, pb | 32'h1);
		frame(40, 16'h0800, 0, -1, -1, 0, 3'h0, 0);
		wr(REG_CTRL, pb);
		cnt(0);
		chk({39'h0, rx_enable}, 40'h0);
		rd(REG_STAT, 32'h1);
		wr(REG_CTRL, pb | 32'h2);
		cnt(1);
		rd(REG_CTRL, pb);
		wr(REG_CTRL, pb | 32'h1);
		repeat (4) @(posedge clk);
		chk({39'h0, rx_enable}, 40'h1);
		rd(REG_STAT, 32'h0);
		frame(64, 16'h002E, 0, -1, -1, 0, 3'h0, 0);
		txbuf(1, 5, 1, 1, 5, 0, 1);
		pend(0);
		slow <= 1'b1;
		txbuf(2, 7, 1, 0, 12, 0, 1);
		txbuf(0, 5, 0, 1, 12, 1, 1);
		pend(0);
		txbuf(3, 9, 1, 1, 9, 0, 0);
		pend(1);
		txbuf(0, 8, 1, 1, 8, 0, 1);
		pend(0);
		repeat (100) @(posedge clk);
		chk(40'(txq.size()), 40'h0);
		chk(40'(rxq.size()), 40'h0);
		chk({39'h0, usb_wr_ready}, 40'h1);
		rd(REG_STAT, 32'h0);
		rd(REG_TXLV, 32'h0);
		ign = 1'b1;
		txbuf(0, 6, 1, 0, 12, 0, 0);
		txbuf(0, 6, 0, 1, 13, 0, 0);
		pend(0);
		repeat (60) @(posedge clk);
		rd(REG_STAT, 32'h2);
		chk({39'h0, transmitter_error_flag}, 40'h1);
		wr(REG_STAT, 32'h2);
		rd(REG_STAT, 32'h0);
		txbuf(0, 5, 1, 1, 6, 0, 0);
		pend(0);
		repeat (60) @(posedge clk);
		rd(REG_STAT, 32'h2);
		close_out();
	end
endmodule : test_usb_ethernet_frame_fifo_ctrl
`default_nettype wire
